/* File: abs_fifo.sv */
// Purpose: flop-based message queue with honest full and empty
// Assumes: single clock, async active-low reset
// Notes: simultaneous push and pop allowed when neither full nor empty blocks
module abs_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // both sides
    abs_fifo_if.queue q
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign q.wr_ready = (count_r != (AW+1)'(DEPTH));
    assign q.rd_valid = (count_r != '0);
    assign q.rd_data = mem_r[rd_ptr_r];
    assign push = q.wr_valid && q.wr_ready;
    assign pop = q.rd_valid && q.rd_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= q.wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

/* File: abs_fifo_if.sv */
// Purpose: carrier between scheduler core and its message queue
// Assumes: single clock
// Notes: valid/ready on both sides
interface abs_fifo_if #(parameter int W = 8);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    modport queue (input wr_valid, input wr_data, input rd_ready,
                   output wr_ready, output rd_valid, output rd_data);
    modport user (output wr_valid, output wr_data, output rd_ready,
                  input wr_ready, input rd_valid, input rd_data);
endinterface

/* File: abs_pkg.sv */
// Purpose: shared constants and types for the locator burst scheduler
// Assumes: one frame of slots per UTC minute, slot timebase supplied from outside
// Notes: message descriptors are what the block emits, not encoded bit streams
package abs_pkg;
    localparam int SLOT_W = 12;
    localparam int SUB_W = 14;
    localparam logic [SLOT_W-1:0] SLOTS_PER_FRAME = 12'h8CA;
    localparam logic [SLOT_W-1:0] MSG_SPACING = 12'h04B;
    localparam logic [SLOT_W-1:0] INCR_MIN = 12'h7E9;
    localparam logic [SLOT_W-1:0] INCR_MAX = 12'h9AB;
    localparam logic [8:0] INCR_SPAN = 9'h1C3;
    localparam logic [2:0] MSGS_LAST = 3'h7;
    localparam logic [2:0] BURST_LAST = 3'h7;
    localparam logic [2:0] TIMEOUT_MAX = 3'h7;
    localparam logic [2:0] TEXT_BURST_A = 3'h0;
    localparam logic [2:0] TEXT_BURST_B = 3'h4;
    localparam logic [2:0] TEXT_MSG_A = 3'h4;
    localparam logic [2:0] TEXT_MSG_B = 3'h5;
    localparam logic [5:0] MSG_ID_POS = 6'h01;
    localparam logic [5:0] MSG_ID_TEXT = 6'h0E;
    localparam logic [3:0] NAV_ACTIVE = 4'hE;
    localparam logic RESET_CHAN = 1'b0;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SYNC = 4'h2,
        ST_WAIT = 4'h4,
        ST_PUSH = 4'h8
    } abs_state_t;

    typedef struct packed {
        logic chan;
        logic [5:0] msg_id;
        logic [3:0] nav;
        logic [2:0] timeout;
        logic [SUB_W-1:0] submsg;
        logic [SLOT_W-1:0] slot;
    } abs_msg_t;

    localparam int MSG_W = $bits(abs_msg_t);
endpackage

/* File: abs_rx_model.sv */
// Purpose: stand-in for the receiving stations that take the message stream
// Assumes: same clock as the scheduler
// Notes: slow pacing accepts one cycle in four to exercise the queue
module abs_rx_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // message stream
    input wire logic msg_valid,
    output logic msg_ready,
    // pacing
    input wire logic slow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end
    assign msg_ready = rst_n && (!slow || phase_r == 2'h3);
endmodule

/* File: abs_sched_chk.sv */
// Purpose: port-level checks of the burst scheduler
// Assumes: single clock, active-low async reset
// Notes: bound to every scheduler instance
module abs_sched_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire logic activate_pin,
    input wire logic msg_valid,
    input wire logic msg_ready,
    input wire logic msg_chan,
    input wire logic [5:0] msg_id,
    input wire logic [3:0] msg_nav,
    input wire logic [2:0] msg_timeout,
    input wire logic [abs_pkg::SUB_W-1:0] msg_submsg,
    input wire logic [abs_pkg::SLOT_W-1:0] msg_slot,
    input wire logic active
);
    import abs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_r;
    logic last_chan_r;
    wire logic take = msg_valid && msg_ready;
    wire logic rep = msg_valid && msg_id == 6'h01;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_r <= 1'b0;
            last_chan_r <= 1'b0;
        end else if (take) begin
            seen_r <= 1'b1;
            last_chan_r <= msg_chan;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    nav_report_a: assert property (rep |-> msg_nav == 4'hE)
        else $error("report nav status wrong");
    id_legal_a: assert property (msg_valid |-> msg_id == 6'h01 || msg_id == 6'h0E)
        else $error("unknown message kind");
    sub_zero_a: assert property (
        rep && (msg_timeout == 3'h7 || msg_timeout == 3'h5 || msg_timeout == 3'h3)
        |-> msg_submsg == 14'h0000) else $error("sub-message not zero");
    sub_slot_a: assert property (
        rep && (msg_timeout == 3'h6 || msg_timeout == 3'h4 || msg_timeout == 3'h2)
        |-> msg_submsg == 14'(msg_slot)) else $error("sub-message not slot");
    sub_utc_a: assert property (
        rep && msg_timeout == 3'h1 |-> msg_submsg[8] == 1'b0 && msg_submsg[1:0] == 2'h0
        && msg_submsg[7:2] < 6'h3C) else $error("utc sub-message malformed");
    sub_incr_a: assert property (
        rep && msg_timeout == 3'h0 |-> msg_submsg >= 14'h07E9 && msg_submsg <= 14'h09AB)
        else $error("increment out of range");
    chan_alt_a: assert property (take && seen_r |-> msg_chan != last_chan_r)
        else $error("two messages on one channel");
    text_clean_a: assert property (msg_valid && msg_id == 6'h0E |-> msg_nav == 4'h0
        && msg_timeout == 3'h0) else $error("text carries report fields");
    idle_stop_a: assert property (!activate_pin [*8] |-> !active)
        else $error("active without activation");
    offer_hold_a: assert property (msg_valid && !msg_ready |=> msg_valid
        && $stable(msg_slot) && $stable(msg_submsg)) else $error("offer withdrawn");
endmodule
bind abs_scheduler abs_sched_chk i_chk (.clk(clk), .rst_n(rst_n),
    .activate_pin(activate_pin), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_chan(msg_chan), .msg_id(msg_id), .msg_nav(msg_nav), .msg_timeout(msg_timeout),
    .msg_submsg(msg_submsg), .msg_slot(msg_slot), .active(active));

/* File: abs_scheduler.sv */
// Purpose: schedules active-mode locator bursts and composes each message descriptor
// Assumes: slot_tick/slot_num/utc come from a same-clock UTC-locked timebase
// Notes: one frame of slots is one minute; queue back-pressure delays, never drops, a message

// Overview of operation
// R01: while active, eight messages are sent per burst and one burst starts each frame.
// R02: each position report's communication state pre-announces the slots used later on.
// R03: every position report is message type 1 with navigational status 14.
// R04: the safety text is sent every fourth burst on both channels, replacing two reports.
// R05: consecutive messages always alternate between the two channels.
// R06: first and fifth bursts carry time-out 7 and 3 with sub-message zero.
// R07: in the first and fifth bursts the fifth and sixth messages are the safety text.
// R08: second, fourth and sixth bursts carry time-out 6, 4, 2 with the slot number.
// R09: the third burst carries time-out 5 with sub-message zero.
// R10: the seventh burst carries time-out 1 with the UTC hour and minute.
// R11: the eighth burst carries time-out 0 with a random increment of 2025 to 2475 slots; the code can pick up to 2476.
// R12: after the eighth burst the cycle restarts, optionally beginning on the second channel.
// R13: a wrapping three-bit burst index gives time-out seven minus index and the sub-message.
module abs_scheduler
    import abs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic activate_pin,
    input wire logic start_ais2,
    // timebase
    input wire logic slot_tick,
    input wire logic [abs_pkg::SLOT_W-1:0] slot_num,
    input wire logic [4:0] utc_hour,
    input wire logic [5:0] utc_min,
    input wire logic [8:0] rand_val,
    // message stream
    output logic msg_valid,
    input wire logic msg_ready,
    output logic msg_chan,
    output logic [5:0] msg_id,
    output logic [3:0] msg_nav,
    output logic [2:0] msg_timeout,
    output logic [abs_pkg::SUB_W-1:0] msg_submsg,
    output logic [abs_pkg::SLOT_W-1:0] msg_slot,
    // status
    output logic active,
    output logic [2:0] burst_index
);
    import abs_pkg::*;

    abs_fifo_if #(.W(MSG_W)) q ();

    logic act_s1_r;
    logic act_s2_r;
    logic act_d_r;
    abs_state_t state_r;
    logic [2:0] burst_r;
    logic [2:0] msg_r;
    logic chan_r;
    logic first_chan_r;
    logic [SLOT_W-1:0] base_r;
    logic [SLOT_W-1:0] next_slot_r;
    logic [SLOT_W-1:0] incr_r;
    abs_msg_t pend_r;
    logic [2:0] timeout;
    logic is_text;
    logic [SUB_W-1:0] submsg;
    logic [SLOT_W-1:0] step_slot;
    logic [SLOT_W-1:0] new_base;
    logic [SLOT_W-1:0] incr_pick;
    logic fire;
    logic act_rise;
    logic pushed;
    logic out_take;
    abs_msg_t head;

    function automatic logic [SLOT_W-1:0] wrap_add(input logic [SLOT_W-1:0] a,
                                                   input logic [SLOT_W-1:0] b);
        logic [SLOT_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= {1'b0, SLOTS_PER_FRAME}) begin
            s = s - {1'b0, SLOTS_PER_FRAME};
        end
        return s[SLOT_W-1:0];
    endfunction

    // activation pin synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_s1_r <= 1'b0;
            act_s2_r <= 1'b0;
            act_d_r <= 1'b0;
        end else begin
            act_s1_r <= activate_pin;
            act_s2_r <= act_s1_r;
            act_d_r <= act_s2_r;
        end
    end

    assign act_rise = act_s2_r && !act_d_r;
    assign fire = slot_tick && (slot_num == next_slot_r);
    assign pushed = (state_r == ST_PUSH) && q.wr_ready;

    // R13: time-out from burst index
    assign timeout = TIMEOUT_MAX - burst_r;

    // R04: text every fourth burst
    // R07: fifth and sixth messages of first and fifth bursts
    assign is_text = ((burst_r == TEXT_BURST_A) || (burst_r == TEXT_BURST_B))
                     && ((msg_r == TEXT_MSG_A) || (msg_r == TEXT_MSG_B));

    // R11: increment folded into 2025 to 2476, one above the allowed 2475
    assign incr_pick = (rand_val > INCR_SPAN)
                       ? INCR_MIN + SLOT_W'(rand_val - INCR_SPAN - 9'h001)
                       : INCR_MIN + SLOT_W'(rand_val);

    // R02: sub-message kind chosen by time-out
    always_comb begin
        submsg = '0;
        unique case (timeout)
            // R06: zero for 7 and 3
            // R09: zero for 5
            3'h7, 3'h5, 3'h3: submsg = '0;
            // R08: slot number for 6, 4, 2
            3'h6, 3'h4, 3'h2: submsg = SUB_W'(next_slot_r);
            // R10: UTC hour and minute
            3'h1: submsg = {utc_hour, 1'b0, utc_min, 2'b00};
            // R11: increment to next burst
            3'h0: submsg = SUB_W'(incr_r);
        endcase
    end

    // R01: eight messages spaced evenly in the frame
    assign step_slot = wrap_add(next_slot_r, MSG_SPACING);
    assign new_base = (burst_r == BURST_LAST) ? wrap_add(base_r, incr_r) : base_r;

    // scheduler state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else if (!act_s2_r) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: state_r <= ST_SYNC;
                ST_SYNC: if (slot_tick) state_r <= ST_PUSH;
                ST_WAIT: if (fire) state_r <= ST_PUSH;
                ST_PUSH: if (q.wr_ready) state_r <= ST_WAIT;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // slot plan and counters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_r <= '0;
            msg_r <= '0;
            base_r <= '0;
            next_slot_r <= '0;
            incr_r <= INCR_MIN;
        end else if (act_rise) begin
            burst_r <= '0;
            msg_r <= '0;
        end else if (state_r == ST_SYNC && slot_tick) begin
            base_r <= slot_num;
            next_slot_r <= slot_num;
        end else if (pushed) begin
            if (msg_r == MSGS_LAST) begin
                // R12: cycle restarts after eighth burst
                // R13: index wraps naturally
                burst_r <= burst_r + 3'h1;
                msg_r <= '0;
                base_r <= new_base;
                // R02: same slots reused until time-out ends
                next_slot_r <= new_base;
                if (burst_r == BURST_LAST - 3'h1) begin
                    incr_r <= incr_pick;
                end
            end else begin
                msg_r <= msg_r + 3'h1;
                next_slot_r <= step_slot;
            end
        end
    end

    // channel alternation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_r <= RESET_CHAN;
            first_chan_r <= RESET_CHAN;
        end else if (act_rise) begin
            // R12: start channel caught at activation
            first_chan_r <= start_ais2;
            chan_r <= start_ais2;
        end else if (pushed) begin
            // R05: flip every message
            chan_r <= ~chan_r;
        end
    end

    // descriptor composed at the firing slot
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= '0;
        end else if ((state_r == ST_WAIT && fire) || (state_r == ST_SYNC && slot_tick)) begin
            pend_r.chan <= chan_r;
            pend_r.slot <= (state_r == ST_SYNC) ? slot_num : next_slot_r;
            if (is_text) begin
                pend_r.msg_id <= MSG_ID_TEXT;
                pend_r.nav <= '0;
                pend_r.timeout <= '0;
                pend_r.submsg <= '0;
            end else begin
                // R03: report type and status
                pend_r.msg_id <= MSG_ID_POS;
                pend_r.nav <= NAV_ACTIVE;
                pend_r.timeout <= timeout;
                pend_r.submsg <= (state_r == ST_SYNC) ? SUB_W'(0) : submsg;
            end
        end
    end

    assign q.wr_valid = (state_r == ST_PUSH);
    assign q.wr_data = pend_r;

    abs_fifo #(.W(MSG_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .q(q)
    );

    // registered output stage
    assign out_take = !msg_valid || msg_ready;
    assign q.rd_ready = out_take;
    assign head = q.rd_data;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_valid <= 1'b0;
            msg_chan <= 1'b0;
            msg_id <= '0;
            msg_nav <= '0;
            msg_timeout <= '0;
            msg_submsg <= '0;
            msg_slot <= '0;
        end else if (out_take) begin
            msg_valid <= q.rd_valid;
            if (q.rd_valid) begin
                msg_chan <= head.chan;
                msg_id <= head.msg_id;
                msg_nav <= head.nav;
                msg_timeout <= head.timeout;
                msg_submsg <= head.submsg;
                msg_slot <= head.slot;
            end
        end
    end

    // status outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
            burst_index <= '0;
        end else begin
            active <= (state_r != ST_IDLE);
            burst_index <= burst_r;
        end
    end
endmodule

/* File: testbench.sv */
// Purpose: self-checking bench running one full eight-burst cycle and its wrap
// Assumes: slot every 4 cycles, fixed utc and random input
// Notes: accepted messages are queued by a monitor and compared in order
module testbench;
    import abs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] to;
        logic [1:0] kind;
    } abs_row_t;
    // burst rows: time-out and sub-message kind (0 zero, 1 slot, 2 utc, 3 incr)
    abs_row_t rows [8] = '{'{3'h7, 2'h0}, '{3'h6, 2'h1}, '{3'h5, 2'h0}, '{3'h4, 2'h1},
                           '{3'h3, 2'h0}, '{3'h2, 2'h1}, '{3'h1, 2'h2}, '{3'h0, 2'h3}};
    // 2025 plus the random input
    localparam logic [11:0] INCR_EXP = 12'h84D;
    logic clk, rst_n, activate_pin, start_ais2, slot_tick, slow;
    logic [11:0] slot_num;
    logic [4:0] utc_hour;
    logic [5:0] utc_min;
    logic [8:0] rand_val;
    logic msg_valid, msg_ready, msg_chan, active;
    logic [5:0] msg_id;
    logic [3:0] msg_nav;
    logic [2:0] msg_timeout, burst_index;
    logic [13:0] msg_submsg;
    logic [11:0] msg_slot, base;
    logic have_base;
    int failures = 0;
    int n_tests = 0;
    abs_msg_t got_q[$];
    abs_msg_t m;
    abs_scheduler i_dut (.clk(clk), .rst_n(rst_n), .activate_pin(activate_pin),
        .start_ais2(start_ais2), .slot_tick(slot_tick), .slot_num(slot_num),
        .utc_hour(utc_hour), .utc_min(utc_min), .rand_val(rand_val),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_chan(msg_chan), .msg_id(msg_id),
        .msg_nav(msg_nav), .msg_timeout(msg_timeout), .msg_submsg(msg_submsg),
        .msg_slot(msg_slot), .active(active), .burst_index(burst_index));
    abs_rx_model i_rx (.clk(clk), .rst_n(rst_n), .msg_valid(msg_valid),
        .msg_ready(msg_ready), .slow(slow));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        slot_tick = 1'b0;
        slot_num = 12'h000;
        forever begin
            repeat (3) @(posedge clk);
            #1 slot_tick = 1'b1;
            slot_num = (slot_num == 12'h8C9) ? 12'h000 : slot_num + 12'h001;
            @(posedge clk);
            #1 slot_tick = 1'b0;
        end
    end
    // base slot is the first tick seen while active
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            have_base = 1'b0;
        end else if (active && slot_tick && !have_base) begin
            base = slot_num;
            have_base = 1'b1;
        end
        if (rst_n && msg_valid && msg_ready) begin
            got_q.push_back({msg_chan, msg_id, msg_nav, msg_timeout, msg_submsg, msg_slot});
        end
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic next_msg(output abs_msg_t g);
        int n;
        n = 0;
        while (got_q.size() == 0 && n < 12000) begin
            @(posedge clk);
            n++;
        end
        g = '0;
        if (got_q.size() == 0) begin
            check(64'h0, 64'h1);
        end else begin
            g = got_q.pop_front();
        end
    endtask
    function automatic abs_msg_t exp_msg(input abs_row_t r, input int k,
                                         input logic [11:0] bs, input logic c0);
        abs_msg_t e;
        logic txt;
        txt = (r.to == 3'h7 || r.to == 3'h3) && (k == 4 || k == 5);
        e.slot = 12'((int'(bs) + 75 * k) % 2250);
        e.chan = c0 ^ k[0];
        e.msg_id = txt ? 6'h0E : 6'h01;
        e.nav = txt ? 4'h0 : 4'hE;
        e.timeout = txt ? 3'h0 : r.to;
        case (r.kind)
            2'h1: e.submsg = 14'(e.slot);
            2'h2: e.submsg = {utc_hour, 1'b0, utc_min, 2'b00};
            2'h3: e.submsg = 14'(INCR_EXP);
            default: e.submsg = 14'h0000;
        endcase
        if (txt) begin
            e.submsg = 14'h0000;
        end
        return e;
    endfunction
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        report_and_stop;
    end
    initial begin
        rst_n = 1'b0;
        activate_pin = 1'b0;
        start_ais2 = 1'b0;
        slow = 1'b0;
        utc_hour = 5'h0C;
        utc_min = 6'h1E;
        rand_val = 9'h064;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        #1 activate_pin = 1'b1;
        for (int b = 0; b < 9; b++) begin
            slow = b[0];
            for (int k = 0; k < 8; k++) begin
                next_msg(m);
                check(m, exp_msg(rows[b % 8], k, (b == 8) ? 12'((int'(base) + int'(INCR_EXP)) % 2250) : base, 1'b0));
            end
            $display("burst %0d done", b);
        end
        #1 rst_n = 1'b0;
        #1 check({msg_valid, active, burst_index}, 64'h0);
        start_ais2 = 1'b1;
        @(posedge clk);
        #1 rst_n = 1'b1;
        got_q.delete();
        $display("mid-run reset done");
        for (int k = 0; k < 2; k++) begin
            next_msg(m);
            check(m, exp_msg(rows[0], k, base, 1'b1));
        end
        $display("second channel start done");
        #1 activate_pin = 1'b0;
        repeat (8) @(posedge clk);
        #1 check(active, 64'h0);
        $display("deactivation done");
        report_and_stop;
    end
endmodule
